// ===== verif/amp_leader_model.sv
// Leader amplifier as a follower sees it: oscillator pair and link clock.
// Assumes its reset pin shares one net with the device under test.
`timescale 1ns/100ps

module amp_leader_model (
    input wire logic reset_pin_n,
    input wire logic crossed,
    output logic link_clock,
    output logic pos_seen,
    output logic neg_seen
);
    // ==========================================
    // Oscillator, halted while reset is low
    logic osc_reg = 1'b0;
    logic run_reg = 1'b0;
    logic pos_line;
    logic neg_line;

    always begin
        wait (reset_pin_n === 1'b1); // Common reset release starts all devices
        #45.3;
        run_reg = 1'b1;
        while (reset_pin_n === 1'b1) begin // Fixed period, trim not modelled
            osc_reg = 1'b1;
            #32;
            osc_reg = 1'b0;
            #32;
        end
        run_reg = 1'b0;
    end

    // Idle pulls: positive line low, negative high
    assign pos_line = (reset_pin_n && run_reg) ? osc_reg : 1'b0;
    assign neg_line = (reset_pin_n && run_reg) ? ~osc_reg : 1'b1;
    // Crossed pair swaps the lines at the follower
    assign pos_seen = crossed ? neg_line : pos_line;
    assign neg_seen = crossed ? pos_line : neg_line;
    assign link_clock = pos_seen;
endmodule // amp_leader_model

// ===== verif/amp_pwm_sync_and_gain_config_bench.sv
// Self-checking bench for strap capture, oscillator link and PWM timing.
// Assumes the package, the design and the leader model are compiled first.
`timescale 1ns/100ps

module amp_pwm_sync_and_gain_config_bench;
    import amp_pwm_pkg::*;

    // ==========================================
    // Signals
    localparam int PERIOD_CLOCKS = 48 * 8;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic reset_pin_n = 1'b0;
    logic [7:0] gain_role_strap = 8'h00;
    logic trim_sup = 1'b0;
    logic [1:0] freq_trim_input = 2'h0;
    logic head_sel = 1'b0;
    logic crossed = 1'b0;
    logic [1:0][5:0] channel_level = 12'h000;
    logic link_clock, pos_seen, neg_seen;
    logic pos_out, pos_oe_n, neg_out, neg_oe_n, bridge_hiz;
    logic [1:0] half_a, half_b;
    run_cfg_type run_cfg;
    int fails = 0;
    int check_count = 0;

    always #4 clock = ~clock;

    amp_pwm_sync_and_gain_config #(.CHANNELS(2), .PERIOD_TICKS(48), .LEVEL_W(6), .STRAP_ADC_W(8))
    u_amp_pwm_sync_and_gain_config (
        .clock(clock), .sys_rst(sys_rst), .osc_link_clock(link_clock), .reset_pin_n(reset_pin_n),
        .gain_role_strap(gain_role_strap), .freq_trim_at_analog_supply(trim_sup),
        .freq_trim_input(freq_trim_input), .head_mode_select(head_sel), .osc_pos_line_in(pos_seen),
        .osc_neg_line_in(neg_seen), .channel_level(channel_level), .osc_pos_line_out(pos_out),
        .osc_pos_line_oe_n(pos_oe_n), .osc_neg_line_out(neg_out), .osc_neg_line_oe_n(neg_oe_n),
        .half_a_out(half_a), .half_b_out(half_b), .bridge_hiz(bridge_hiz), .run_cfg(run_cfg));

    amp_leader_model u_amp_leader_model (
        .reset_pin_n(reset_pin_n), .crossed(crossed), .link_clock(link_clock),
        .pos_seen(pos_seen), .neg_seen(neg_seen));

    // ==========================================
    // Tasks
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_num(input string what, input int exp, input int got);
        check_count++;
        if (got != exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0: return bridge_hiz;
            1: return pos_out;
            default: return half_a[0];
        endcase
    endfunction

    // Bounded wait; running out ends the run
    task automatic wait_bit(input int sel, input logic lvl, input int bound);
        int k;
        k = 0;
        while (sig(sel) !== lvl && k < bound) begin
            step(1);
            k++;
        end
        if (sig(sel) !== lvl) begin
            fails++;
            $display("CHECK FAILED wait on signal %0d expected %b seen %b", sel, lvl, sig(sel));
            tally_and_finish();
        end
    endtask

    // Pin held low long enough for the leader model to stop
    task automatic capture(input logic [2:0] s, input logic hm, input logic sup, input logic cr);
        reset_pin_n = 1'b0;
        gain_role_strap = {s, 5'h10};
        head_sel = hm;
        trim_sup = sup;
        crossed = cr;
        step(12);
        reset_pin_n = 1'b1;
        step(6);
        chk_val("run_cfg", {2'h0, s, hm, sup, s[2] & cr}, {2'h0, run_cfg});
    endtask

    task automatic measure(input int ch, input int exp_a, input int exp_b);
        int na;
        int nb;
        na = 0;
        nb = 0;
        repeat (PERIOD_CLOCKS) begin
            step(1);
            na += int'(half_a[ch] === 1'b1);
            nb += int'(half_b[ch] === 1'b1);
        end
        chk_num("half_a high clocks", exp_a, na);
        chk_num("half_b high clocks", exp_b, nb);
    endtask

    task automatic half_period(input int exp);
        int k;
        k = 0;
        wait_bit(1, 1'b0, 40);
        wait_bit(1, 1'b1, 40);
        while (pos_out === 1'b1 && k < 40) begin
            step(1);
            k++;
        end
        chk_num("oscillator half period", exp, k);
    endtask

    // ==========================================
    // Tests
    initial begin
        int k;
        step(4);
        sys_rst = 1'b0;
        step(2);
        chk_val("bridge_hiz", 8'h01, {7'h00, bridge_hiz});
        chk_val("pair oe_n", 8'h03, {6'h00, pos_oe_n, neg_oe_n});
        $display("Test reset state done");
        for (int s = 0; s < 8; s++) begin
            capture(3'(s), s[1], 1'b0, s[0]);
            gain_role_strap = ~gain_role_strap;
            head_sel = ~head_sel;
            step(10);
            chk_val("held run_cfg", {2'h0, 3'(s), s[1], 1'b0, s[2] & s[0]}, {2'h0, run_cfg});
        end
        $display("Test strap decode done");
        capture(3'h4, 1'b0, 1'b1, 1'b0);
        step(2 * PERIOD_CLOCKS);
        chk_val("pair oe_n external", 8'h03, {6'h00, pos_oe_n, neg_oe_n});
        measure(0, PERIOD_CLOCKS / 2, PERIOD_CLOCKS / 2);
        reset_pin_n = 1'b0;
        // Leader clock stops with the shared pin; ramp down must still end
        wait_bit(0, 1'b1, 8 * PERIOD_CLOCKS);
        $display("Test external clock done");
        freq_trim_input = 2'h3;
        capture(3'h1, 1'b0, 1'b0, 1'b0);
        step(20);
        chk_val("pair oe_n leader", 8'h00, {6'h00, pos_oe_n, neg_oe_n});
        chk_val("pair complement", 8'h01, {7'h00, pos_out ^ neg_out});
        half_period(7);
        freq_trim_input = 2'h0;
        capture(3'h0, 1'b0, 1'b0, 1'b0);
        half_period(4);
        $display("Test local oscillator done");
        step(PERIOD_CLOCKS);
        chk_val("bridge_hiz running", 8'h00, {7'h00, bridge_hiz});
        measure(0, PERIOD_CLOCKS / 2, PERIOD_CLOCKS / 2);
        wait_bit(2, 1'b0, 400);
        wait_bit(2, 1'b1, 400);
        k = 0;
        while (half_a[1] !== 1'b1 && k < 40) begin
            step(1);
            k++;
        end
        chk_num("channel delay clocks", 8, k);
        channel_level = {6'h0A, 6'h0A};
        step(23 * PERIOD_CLOCKS);
        measure(0, 34 * 8, 14 * 8);
        $display("Test continuous mode done");
        channel_level = 12'h000;
        capture(3'h0, 1'b1, 1'b0, 1'b0);
        step(PERIOD_CLOCKS);
        measure(0, 4 * 8, 4 * 8);
        channel_level = {6'h14, 6'h14};
        step(24 * PERIOD_CLOCKS);
        measure(1, 40 * 8, 0);
        $display("Test low-idle mode done");
        reset_pin_n = 1'b0;
        step(20);
        chk_val("bridge_hiz ramping", 8'h00, {7'h00, bridge_hiz});
        wait_bit(0, 1'b1, 26 * PERIOD_CLOCKS);
        step(2);
        chk_val("halves off", 8'h00, {4'h0, half_a, half_b});
        $display("Test ramp down done");
        tally_and_finish();
    end
endmodule // amp_pwm_sync_and_gain_config_bench

// ===== verilog/amp_pwm_consts.svh
// Constants for the class-D switching, strap and oscillator logic.
// Assumes inclusion by bare name from the package only.
`ifndef AMP_PWM_CONSTS_SVH
`define AMP_PWM_CONSTS_SVH

// =====================================================================
// Strap decode
`define STRAP_STATE_W 3
`define STRAP_ROLE_BIT 2

// =====================================================================
// Phase plan: 360 / 30 degrees gives twelve phase slots per period
`define PHASE_SLOTS 12
`define SLOT_LEADER 0
`define SLOT_PHASE_ONE 1
`define SLOT_PHASE_TWO 2
`define CH_DELAY_TICKS 1

// =====================================================================
// Modulation shaping, in oscillator ticks
`define HEAD_IDLE_DUTY 4
`define HEAD_SMALL_LEVEL 8

// =====================================================================
// Local oscillator half period, in system clocks
`define LOCAL_HALF_BASE 4
`define LOCAL_HALF_STEP 1
`define TRIM_CODE_W 2
// Link silence, in system clocks, before a ramp down falls back to local ticks
`define LINK_QUIET_CLOCKS 32

`endif

// ===== verilog/amp_pwm_pkg.sv
// Types shared by the switching and configuration logic.
// Assumes the constants header is on the include path.
`include "amp_pwm_consts.svh"

package amp_pwm_pkg;

    typedef struct packed {
        logic follower;
        logic [1:0] gain_step;
    } strap_cfg_type;

    typedef struct packed {
        strap_cfg_type strap;
        logic head_mode;
        logic osc_external;
        logic phase_two;
    } run_cfg_type;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
    } duty_pair_type;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RAMP_UP = 2'b01,
        ST_RUN = 2'b10,
        ST_RAMP_DOWN = 2'b11
    } amp_state_type;

endpackage

// ===== verilog/amp_pwm_sync_and_gain_config.sv
// Strap decode, oscillator link and PWM timing of a class-D amplifier.
// Assumes a free 125 MHz system clock and, for a follower, the leader's
// oscillator clock received on its own clock port.
//
// Summary of operation
// - The strap converter sample is classified into one of eight states.
// - States one to four mean leader role with gain steps 18, 24, 30 and 34 dB.
// - States five to eight mean follower role with gain steps 18, 24, 30 and 34 dB.
// - Gain and role are caught on the rising edge of the reset pin and held while it stays high.
// - Leader, phase-one follower and phase-two follower switch 30 degrees apart.
// - A follower takes phase one on a straight clock pair and phase two on a crossed one.
// - A frequency-trim input tied to the analog supply disables the local oscillator, except in a ramp down after the link goes quiet.
// - With the local oscillator off the pair becomes inputs and the external clock drives switching.
// - In leader role the trim resistance chooses the switching frequency.
// - Continuous mode switches both half-bridges every period while the ramp-clamped level stays under 24 either way.
// - Low-idle mode switches both half-bridges at reduced duty while idle or quiet.
// - Low-idle mode stops one half-bridge once the level is high.
// - Linked channels get a delay so no two idle channels switch together.
// - Reset pin low ramps the outputs down and then leaves the bridges high impedance.
`timescale 1ns/100ps

module amp_pwm_sync_and_gain_config
    import amp_pwm_pkg::*;
#(
    parameter int CHANNELS = 2,
    parameter int PERIOD_TICKS = 48,
    parameter int LEVEL_W = 6,
    parameter int STRAP_ADC_W = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic osc_link_clock,
    input wire logic reset_pin_n,
    input wire logic [STRAP_ADC_W-1:0] gain_role_strap,
    input wire logic freq_trim_at_analog_supply,
    input wire logic [`TRIM_CODE_W-1:0] freq_trim_input,
    input wire logic head_mode_select,
    input wire logic osc_pos_line_in,
    input wire logic osc_neg_line_in,
    input wire logic [CHANNELS-1:0][LEVEL_W-1:0] channel_level,
    output logic osc_pos_line_out,
    output logic osc_pos_line_oe_n,
    output logic osc_neg_line_out,
    output logic osc_neg_line_oe_n,
    output logic [CHANNELS-1:0] half_a_out,
    output logic [CHANNELS-1:0] half_b_out,
    output logic bridge_hiz,
    output run_cfg_type run_cfg
);

    localparam int HALF_TICKS = PERIOD_TICKS / 2;
    localparam int SLOT_TICKS = PERIOD_TICKS / `PHASE_SLOTS;

    // =================================================================
    // Helpers
    function automatic strap_cfg_type classify(input logic [STRAP_ADC_W-1:0] code);
        logic [`STRAP_STATE_W-1:0] state;
        strap_cfg_type c;
        state = code[STRAP_ADC_W-1 -: `STRAP_STATE_W];
        c.follower = state[`STRAP_ROLE_BIT];
        c.gain_step = state[1:0];
        return c;
    endfunction

    function automatic duty_pair_type duty_for(input logic [LEVEL_W-1:0] lvl, input logic [7:0] lim,
                                               input logic head);
        int l;
        int m;
        duty_pair_type d;
        l = int'($signed(lvl));
        m = int'(lim);
        if (l > m) begin
            l = m;
        end
        if (l < -m) begin
            l = -m;
        end
        if (!head) begin
            d.a = 8'(HALF_TICKS + l);
            d.b = 8'(HALF_TICKS - l);
        end else if (l < `HEAD_SMALL_LEVEL && l > -`HEAD_SMALL_LEVEL) begin
            d.a = 8'(`HEAD_IDLE_DUTY + (l > 0 ? l : 0));
            d.b = 8'(`HEAD_IDLE_DUTY + (l < 0 ? -l : 0));
        end else if (l > 0) begin
            d.a = 8'(2 * l);
            d.b = 8'h00;
        end else begin
            d.a = 8'h00;
            d.b = 8'(-2 * l);
        end
        return d;
    endfunction

    // =================================================================
    // Pin synchronisers
    logic rst_pin_s1_reg, rst_pin_s2_reg, rst_pin_s3_reg;
    logic trim_sup_s1_reg, trim_sup_s2_reg;
    logic head_s1_reg, head_s2_reg;
    logic pos_s1_reg, pos_s2_reg;
    logic neg_s1_reg, neg_s2_reg;
    logic [STRAP_ADC_W-1:0] strap_s1_reg, strap_s2_reg;
    logic [`TRIM_CODE_W-1:0] trim_s1_reg, trim_s2_reg;
    logic rst_rise, rst_fall;

    // Strap and trim levels are static straps, so word-wise sync is safe
    always_ff @(posedge clock) begin
        rst_pin_s1_reg <= reset_pin_n;
        rst_pin_s2_reg <= rst_pin_s1_reg;
        rst_pin_s3_reg <= rst_pin_s2_reg;
        trim_sup_s1_reg <= freq_trim_at_analog_supply;
        trim_sup_s2_reg <= trim_sup_s1_reg;
        head_s1_reg <= head_mode_select;
        head_s2_reg <= head_s1_reg;
        pos_s1_reg <= osc_pos_line_in;
        pos_s2_reg <= pos_s1_reg;
        neg_s1_reg <= osc_neg_line_in;
        neg_s2_reg <= neg_s1_reg;
        strap_s1_reg <= gain_role_strap;
        strap_s2_reg <= strap_s1_reg;
        trim_s1_reg <= freq_trim_input;
        trim_s2_reg <= trim_s1_reg;
    end

    assign rst_rise = rst_pin_s2_reg && !rst_pin_s3_reg;
    assign rst_fall = !rst_pin_s2_reg && rst_pin_s3_reg;

    // =================================================================
    // Configuration latch
    run_cfg_type cfg_reg;
    strap_cfg_type strap_now;

    assign strap_now = classify(strap_s2_reg);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfg_reg <= '0;
        end else if (rst_rise) begin
            cfg_reg.strap <= strap_now;
            cfg_reg.head_mode <= head_s2_reg;
            cfg_reg.osc_external <= trim_sup_s2_reg;
            // Leader's idle pulls show through: positive high and negative low means crossed
            cfg_reg.phase_two <= strap_now.follower && pos_s2_reg && !neg_s2_reg;
        end
    end

    assign run_cfg = cfg_reg;

    // =================================================================
    // Link domain: one toggle per received oscillator rising edge
    logic ext_run_reg;
    logic link_run_s1_reg, link_run_s2_reg;
    logic link_toggle_reg;

    // Link clock may stop; the toggle is held clear until enabled
    always_ff @(posedge osc_link_clock) begin
        link_run_s1_reg <= ext_run_reg;
        link_run_s2_reg <= link_run_s1_reg;
        link_toggle_reg <= link_run_s2_reg ? !link_toggle_reg : 1'b0;
    end

    logic tog_s1_reg, tog_s2_reg, tog_s3_reg;

    always_ff @(posedge clock) begin
        tog_s1_reg <= link_toggle_reg;
        tog_s2_reg <= tog_s1_reg;
        tog_s3_reg <= tog_s2_reg;
    end

    // =================================================================
    // State machine
    amp_state_type state_reg;
    logic [7:0] ramp_reg;
    logic [7:0] pos_reg;
    logic tick;
    logic period_end;

    assign period_end = tick && (pos_reg == 8'(PERIOD_TICKS - 1));

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= ST_OFF;
        end else if (rst_rise) begin
            state_reg <= ST_RAMP_UP;
        end else begin
            unique case (state_reg)
                ST_OFF: begin
                    state_reg <= ST_OFF;
                end
                ST_RAMP_UP: begin
                    if (rst_fall) begin
                        state_reg <= ST_RAMP_DOWN;
                    end else if (period_end && ramp_reg == 8'(HALF_TICKS)) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (rst_fall) begin
                        state_reg <= ST_RAMP_DOWN;
                    end
                end
                ST_RAMP_DOWN: begin
                    if (period_end && ramp_reg == 8'h00) begin
                        state_reg <= ST_OFF;
                    end
                end
            endcase
        end
    end

    // Ramp limit moves one tick per period for a soft start and stop
    always_ff @(posedge clock) begin
        if (sys_rst || rst_rise) begin
            ramp_reg <= 8'h00;
        end else if (period_end) begin
            if (state_reg == ST_RAMP_UP && ramp_reg < 8'(HALF_TICKS)) begin
                ramp_reg <= ramp_reg + 8'h01;
            end else if (state_reg == ST_RAMP_DOWN && ramp_reg != 8'h00) begin
                ramp_reg <= ramp_reg - 8'h01;
            end
        end
    end

    // =================================================================
    // Oscillator: local divider or external ticks
    logic [7:0] div_cnt_reg;
    logic [7:0] local_half;
    logic osc_local_reg;
    logic local_rise;
    logic [7:0] quiet_cnt_reg;
    logic ext_fallback;

    // A leader sharing our reset pin stops its clock; local ticks then finish the ramp down
    assign ext_fallback = state_reg == ST_RAMP_DOWN && quiet_cnt_reg == 8'(`LINK_QUIET_CLOCKS);
    assign local_half = 8'(`LOCAL_HALF_BASE + int'(trim_s2_reg) * `LOCAL_HALF_STEP);
    assign local_rise = !osc_local_reg && (div_cnt_reg + 8'h01 >= local_half);
    assign tick = cfg_reg.osc_external && !ext_fallback ? (tog_s2_reg ^ tog_s3_reg) : local_rise;

    always_ff @(posedge clock) begin
        if (sys_rst || rst_rise || (tog_s2_reg ^ tog_s3_reg)) begin
            quiet_cnt_reg <= 8'h00;
        end else if (quiet_cnt_reg != 8'(`LINK_QUIET_CLOCKS)) begin
            quiet_cnt_reg <= quiet_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || rst_rise || state_reg == ST_OFF || (cfg_reg.osc_external && !ext_fallback)) begin
            div_cnt_reg <= 8'h00;
            osc_local_reg <= 1'b0;
        end else if (div_cnt_reg + 8'h01 >= local_half) begin
            div_cnt_reg <= 8'h00;
            osc_local_reg <= !osc_local_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ext_run_reg <= 1'b0;
        end else begin
            ext_run_reg <= cfg_reg.osc_external && state_reg != ST_OFF;
        end
    end

    // Pair is driven only by an active device on its local oscillator; released otherwise so the pulls set idle levels
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            osc_pos_line_out <= 1'b0;
            osc_neg_line_out <= 1'b1;
            osc_pos_line_oe_n <= 1'b1;
            osc_neg_line_oe_n <= 1'b1;
        end else begin
            osc_pos_line_out <= osc_local_reg;
            osc_neg_line_out <= !osc_local_reg;
            osc_pos_line_oe_n <= cfg_reg.osc_external || state_reg == ST_OFF;
            osc_neg_line_oe_n <= cfg_reg.osc_external || state_reg == ST_OFF;
        end
    end

    // =================================================================
    // Phase position within the switching period
    logic [7:0] dev_off;

    assign dev_off = !cfg_reg.strap.follower ? 8'(`SLOT_LEADER * SLOT_TICKS) :
                     cfg_reg.phase_two ? 8'(`SLOT_PHASE_TWO * SLOT_TICKS) :
                     8'(`SLOT_PHASE_ONE * SLOT_TICKS);

    // Common release starts every device at position zero
    always_ff @(posedge clock) begin
        if (sys_rst || rst_rise) begin
            pos_reg <= 8'h00;
        end else if (period_end) begin
            pos_reg <= 8'h00;
        end else if (tick) begin
            pos_reg <= pos_reg + 8'h01;
        end
    end

    // =================================================================
    // Half-bridge drive
    always_ff @(posedge clock) begin
        duty_pair_type d;
        int t;
        d = '0;
        t = 0;
        if (sys_rst) begin
            half_a_out <= '0;
            half_b_out <= '0;
            bridge_hiz <= 1'b1;
        end else begin
            bridge_hiz <= state_reg == ST_OFF;
            for (int c = 0; c < CHANNELS; c++) begin
                d = duty_for(channel_level[c], ramp_reg, cfg_reg.head_mode);
                t = int'(pos_reg) - int'(dev_off) - c * `CH_DELAY_TICKS;
                if (t < 0) begin
                    t = t + PERIOD_TICKS;
                end
                half_a_out[c] <= state_reg != ST_OFF && t < int'(d.a);
                half_b_out[c] <= state_reg != ST_OFF && t < int'(d.b);
            end
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic big_pos0;

    assign big_pos0 = state_reg == ST_RUN && $signed(channel_level[0]) >= $signed(LEVEL_W'(`HEAD_SMALL_LEVEL));

    strap_hold_a: assert property (rst_pin_s2_reg && !rst_rise |=> $stable(cfg_reg))
        else $error("strap choice changed while reset pin high");
    role_decode_a: assert property (rst_rise |=> {cfg_reg.strap.follower, cfg_reg.strap.gain_step}
                                    == $past(strap_s2_reg[STRAP_ADC_W-1 -: `STRAP_STATE_W]))
        else $error("strap state decoded to wrong role or gain");
    osc_inputs_a: assert property (cfg_reg.osc_external |=> osc_pos_line_oe_n && osc_neg_line_oe_n)
        else $error("oscillator pair driven while external clock used");
    osc_drive_a: assert property (!cfg_reg.osc_external && state_reg == ST_RUN |=> !osc_pos_line_oe_n)
        else $error("leader oscillator pair not driven");
    ad_switch_a: assert property (state_reg == ST_RUN && !cfg_reg.head_mode && period_end
                                  |-> ##[1:1000] $rose(half_a_out[0]) || rst_fall)
        else $error("continuous mode half-bridge did not switch");
    hiz_off_a: assert property (state_reg == ST_OFF |=> bridge_hiz && !half_a_out[0] && !half_b_out[0])
        else $error("bridge not high impedance after ramp down");
    ramp_start_a: assert property (rst_fall && state_reg != ST_OFF |=> state_reg == ST_RAMP_DOWN)
        else $error("reset pin low did not start ramp down");
    head_stop_a: assert property (cfg_reg.head_mode && $past(big_pos0) && big_pos0 && ramp_reg >= 8'(HALF_TICKS)
                                  |-> !half_b_out[0])
        else $error("low-idle quiet half-bridge still switching");

    run_seen_c: cover property (state_reg == ST_RAMP_UP ##1 state_reg == ST_RUN);
    follower_two_c: cover property (rst_rise ##1 cfg_reg.phase_two);
    ramp_done_c: cover property (state_reg == ST_RAMP_DOWN ##1 state_reg == ST_OFF);
    quiet_down_c: cover property (ext_fallback && tick);

endmodule // amp_pwm_sync_and_gain_config
